// ---- rtl/fan_pkg.sv ----
// Constants shared by the fan speed controller files
package fan_pkg;
	// Clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int UPD_STEP_MS = 100;
	localparam int UPD_STEP_CYCLES = UPD_STEP_MS * (CLK_HZ / 1000);
	localparam int TACH_GATE_MS = 1000;
	localparam int TACH_GATE_CYCLES = TACH_GATE_MS * (CLK_HZ / 1000);
	localparam int KHZ_DIV = CLK_HZ / 1000;
	localparam logic [3:0] INT_MAX_UNITS = 4'h a;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_THRESH = 8'h04;
	localparam logic [7:0] OFF_SPEED = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_NONE = 8'hff;
	// Control register fields
	localparam int AUTO_BIT = 0;
	localparam int SEL_BIT = 1;
	localparam int HIGH_BIT = 2;
	localparam int LF_LSB = 4;
	localparam int KHZ_LSB = 8;
	localparam int PPR_LSB = 16;
	localparam int INT_LSB = 20;
	localparam int STEP_LSB = 24;
	localparam int DEF_LSB = 28;
	// Threshold and speed fields
	localparam int LO_LSB = 0;
	localparam int HI_LSB = 8;
	localparam int MIN_LSB = 0;
	localparam int LSPD_LSB = 8;
	localparam int USPD_LSB = 16;
	localparam int MAX_LSB = 24;
	// Status fields
	localparam int RPM_LSB = 0;
	localparam int DUTY_LSB = 16;
	localparam int TGT_LSB = 24;
	// Reset values and write masks
	localparam logic [31:0] CTRL_RST = 32'h8711_1f45;
	localparam logic [31:0] CTRL_MASK = 32'hf7f3_3f77;
	localparam logic [31:0] THRESH_RST = 32'h0000_0805;
	localparam logic [31:0] THRESH_MASK = 32'h0000_0f0f;
	localparam logic [31:0] SPEED_RST = 32'h1410_0c00;
	localparam logic [31:0] SPEED_MASK = 32'h1f1f_1f1f;
	localparam logic [6:0] DUTY_RST = 7'h64;
	localparam logic [5:0] HF_KHZ_RST = 6'h1f;
	localparam logic [19:0] PER_RST = 20'(KHZ_DIV / 31);
	// Low range periods in clock cycles, 11.0 Hz up to 88.2 Hz
	localparam logic [19:0] LF_PERIOD [8] = '{20'h ddf33, 20'h a6140, 20'h 6e789,
		20'h 530a8, 20'h 4529e, 20'h 375c5, 20'h 29854, 20'h 1bad3};
	// Fixed duties and step widths in percent
	localparam logic [6:0] DEF_PCT [9] = '{7'h00, 7'h0a, 7'h19, 7'h28, 7'h32,
		7'h3c, 7'h4b, 7'h5a, 7'h64};
	localparam logic [6:0] STEP_PCT [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10,
		7'h20, 7'h40, 7'h64};
	// RPM per counted pulse over a one second gate, by pulses per rev
	localparam logic [5:0] RPM_PER_PULSE [4] = '{6'h3c, 6'h1e, 6'h14, 6'h0f};
	localparam logic [10:0] PULSE_MAX = 11'h444;
endpackage : fan_pkg

// ---- rtl/fan_pwm.sv ----
// PWM generator that only takes new period and duty at a period boundary
`timescale 1ns/1ps
`default_nettype none
module fan_pwm (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Requested period in cycles and duty in percent
	input wire logic [19:0] i_period,
	input wire logic [6:0] i_duty,
	// Fan drive
	output logic o_pwm
);
	logic [19:0] cnt_reg, cnt_next; // Position inside the period
	logic [19:0] per_reg, per_next; // Period in force
	logic [6:0] duty_reg, duty_next; // Duty in force
	logic pwm_reg, pwm_next; // Registered output

	// Next state; settings are latched only when a period ends
	always_comb begin
		cnt_next = cnt_reg + 20'h00001;
		per_next = per_reg;
		duty_next = duty_reg;
		if (cnt_reg >= per_reg - 20'h00001) begin
			cnt_next = 20'h00000;
			per_next = i_period;
			duty_next = i_duty;
		end
		// Multiply instead of divide: high while cnt/per < duty/100
		pwm_next = (27'(cnt_next) * 27'h0000064) < (27'(per_next) * 27'(duty_next));
	end

	// Registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_reg <= 20'h00000;
			per_reg <= fan_pkg::PER_RST;
			duty_reg <= fan_pkg::DUTY_RST;
			pwm_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			per_reg <= per_next;
			duty_reg <= duty_next;
			pwm_reg <= pwm_next;
		end
	end

	assign o_pwm = pwm_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	period_latch_a: assert property ($changed(per_reg) |-> $past(cnt_reg) >= $past(per_reg) - 20'h00001)
		else $error("period changed inside a PWM period");
	// First edge after reset still shows the flop's reset level, so it is skipped
	period_start_a: assert property ($past(i_rst_b) && cnt_reg == 20'h00000 |-> pwm_reg == (duty_reg != 7'h00))
		else $error("PWM level wrong at period start");
	fan_off_a: assert property (duty_reg == 7'h00 |-> !pwm_reg)
		else $error("PWM high with zero duty");
endmodule : fan_pwm
`default_nettype wire

// ---- rtl/fan_tach.sv ----
// Tachometer pulse counter giving revolutions per minute
`timescale 1ns/1ps
`default_nettype none
module fan_tach #(
	parameter int GATE_CYCLES = fan_pkg::TACH_GATE_CYCLES // One second gate
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Tach pulse input and pulses-per-rev code (count minus one)
	input wire logic i_tach,
	input wire logic [1:0] i_ppr_code,
	// Measured speed
	output logic [15:0] o_rpm
);
	logic [31:0] gate_reg, gate_next; // Gate timer
	logic [10:0] pulse_reg, pulse_next; // Pulses in this gate
	logic tprev_reg, tprev_next; // Previous tach level
	logic [15:0] rpm_reg, rpm_next; // Last result
	logic rise; // Tach rising edge

	// Count rising edges; at gate end scale by 60/ppr, exact for 1..4
	always_comb begin
		rise = i_tach && !tprev_reg;
		tprev_next = i_tach;
		gate_next = gate_reg + 32'h1;
		rpm_next = rpm_reg;
		pulse_next = pulse_reg;
		// Saturate so the product always fits sixteen bits
		if (rise && pulse_reg != fan_pkg::PULSE_MAX) begin
			pulse_next = pulse_reg + 11'h001;
		end
		if (gate_reg == 32'(GATE_CYCLES - 1)) begin
			gate_next = 32'h0;
			rpm_next = 16'(17'(pulse_reg) * 17'(fan_pkg::RPM_PER_PULSE[i_ppr_code]));
			pulse_next = rise ? 11'h001 : 11'h000;
		end
	end

	// Registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gate_reg <= 32'h0;
			pulse_reg <= 11'h000;
			// Idle tach line sits high on its pull-up; starting low would count a false edge
			tprev_reg <= 1'b1;
			rpm_reg <= 16'h0000;
		end else begin
			gate_reg <= gate_next;
			pulse_reg <= pulse_next;
			tprev_reg <= tprev_next;
			rpm_reg <= rpm_next;
		end
	end

	assign o_rpm = rpm_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	rpm_scale_a: assert property ($changed(rpm_reg) |-> rpm_reg == 16'(17'($past(pulse_reg)) * 17'(fan_pkg::RPM_PER_PULSE[$past(i_ppr_code)])))
		else $error("RPM not scaled from pulse count");
endmodule : fan_tach
`default_nettype wire

// ---- rtl/fan_speed_controller.sv ----
// Fan speed controller top: AHB-Lite registers, control loop, PWM and tach
`timescale 1ns/1ps
`default_nettype none
// Function
// - Low and high PWM ranges, high default
// - Low range eight frequencies, 35.3 Hz default
// - High range 1 to 63 kHz, 31 default
// - Pulses per revolution 1 to 4, default 2
// - Measured speed readable in RPM
// - Loop recomputes once per 100-1000 ms interval
// - Duty moves at most step width per interval
// - Auto off drives fixed default duty
// - Automatic control switchable, on after reset
// - Temperature source CPU or board, CPU default
// - Lower limit 10-90 C, default 50
// - Upper limit 20-100 C, default 80
// - Below lower limit use minimum speed
// - Lower band uses lower speed, default 60%
// - Upper band uses upper speed, default 80%
// - Above upper limit use maximum speed
module fan_speed_controller #(
	parameter int UPD_STEP_CYCLES = fan_pkg::UPD_STEP_CYCLES, // One 100 ms unit
	parameter int TACH_GATE_CYCLES = fan_pkg::TACH_GATE_CYCLES // One second gate
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic i_hready,
	input wire logic [31:0] i_hwdata,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Temperature sensors in degrees C
	input wire logic [7:0] i_cpu_temp,
	input wire logic [7:0] i_board_temp,
	// Fan
	input wire logic i_tach,
	output logic o_pwm
);
	// Register file
	logic [31:0] ctrl_reg, ctrl_next; // Control word
	logic [31:0] thr_reg, thr_next; // Temperature limits
	logic [31:0] spd_reg, spd_next; // Speed set points
	logic [31:0] rdata_reg, rdata_next; // Read data for the data phase
	logic wpend_reg, wpend_next; // Write data phase pending
	logic [7:0] waddr_reg, waddr_next; // Decoded write offset
	logic addr_ph; // Valid address phase
	logic [7:0] raddr; // Decoded address phase offset
	// Loop timer
	logic [31:0] tcnt_reg, tcnt_next; // Cycles inside a 100 ms unit
	logic [3:0] icnt_reg, icnt_next; // Units inside an interval
	logic tick_reg, tick_next; // One-cycle interval pulse
	// Control loop
	logic [6:0] duty_reg, duty_next; // Duty driven, percent
	logic [6:0] tgt_reg, tgt_next; // Last target, percent
	// Decoded fields
	logic auto_en; // Automatic control on
	logic [5:0] khz; // High range frequency
	logic [3:0] intv; // Interval in 100 ms units, clamped
	logic [3:0] def_sel; // Default duty index, clamped
	logic [6:0] def_pct; // Default duty
	logic [6:0] step_pct; // Step width
	logic [7:0] temp_s; // Selected temperature
	logic [7:0] lo_c; // Lower limit, C
	logic [7:0] hi_c; // Upper limit, C
	logic [7:0] mid_c; // Band boundary, C
	logic [6:0] min_pct, lspd_pct, uspd_pct, max_pct; // Set points
	logic [6:0] tgt; // Target of this interval
	logic [19:0] period; // PWM period in cycles
	logic [15:0] rpm; // Measured speed

	// Speed code in 5% units to percent, capped at full speed
	function automatic logic [6:0] pct(input logic [4:0] c);
		pct = (c > 5'h14) ? 7'h64 : 7'(c) * 7'h05;
	endfunction : pct

	// Field decode with clamping of out-of-range software values
	always_comb begin
		auto_en = ctrl_reg[fan_pkg::AUTO_BIT];
		khz = ctrl_reg[fan_pkg::KHZ_LSB +: 6];
		if (khz == 6'h00) begin
			khz = 6'h01;
		end
		intv = ctrl_reg[fan_pkg::INT_LSB +: 4];
		if (intv == 4'h0) begin
			intv = 4'h1;
		end else if (intv > fan_pkg::INT_MAX_UNITS) begin
			intv = fan_pkg::INT_MAX_UNITS;
		end
		def_sel = ctrl_reg[fan_pkg::DEF_LSB +: 4];
		if (def_sel > 4'h8) begin
			def_sel = 4'h8;
		end
		def_pct = fan_pkg::DEF_PCT[def_sel];
		step_pct = fan_pkg::STEP_PCT[ctrl_reg[fan_pkg::STEP_LSB +: 3]];
		temp_s = ctrl_reg[fan_pkg::SEL_BIT] ? i_board_temp : i_cpu_temp;
		lo_c = 8'(thr_reg[fan_pkg::LO_LSB +: 4]) * 8'h0a;
		hi_c = 8'(thr_reg[fan_pkg::HI_LSB +: 4]) * 8'h0a;
		mid_c = 8'((9'(lo_c) + 9'(hi_c)) >> 1);
		min_pct = pct(spd_reg[fan_pkg::MIN_LSB +: 5]);
		lspd_pct = pct(spd_reg[fan_pkg::LSPD_LSB +: 5]);
		uspd_pct = pct(spd_reg[fan_pkg::USPD_LSB +: 5]);
		max_pct = pct(spd_reg[fan_pkg::MAX_LSB +: 5]);
		// Range select; a division in logic, settled long before use
		if (ctrl_reg[fan_pkg::HIGH_BIT]) begin
			period = 20'(fan_pkg::KHZ_DIV / int'(khz));
		end else begin
			period = fan_pkg::LF_PERIOD[ctrl_reg[fan_pkg::LF_LSB +: 3]];
		end
	end

	// Bus slave: zero wait states, always OKAY, unmapped reads give zero
	always_comb begin
		addr_ph = i_hsel && i_htrans[1] && i_hready;
		raddr = (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : fan_pkg::OFF_NONE;
		wpend_next = addr_ph && i_hwrite;
		waddr_next = raddr;
		ctrl_next = ctrl_reg;
		thr_next = thr_reg;
		spd_next = spd_reg;
		if (wpend_reg) begin
			case (waddr_reg)
				fan_pkg::OFF_CTRL: begin
					ctrl_next = i_hwdata & fan_pkg::CTRL_MASK;
				end
				fan_pkg::OFF_THRESH: begin
					thr_next = i_hwdata & fan_pkg::THRESH_MASK;
				end
				fan_pkg::OFF_SPEED: begin
					spd_next = i_hwdata & fan_pkg::SPEED_MASK;
				end
				default: begin
					// Status and unmapped writes are dropped
				end
			endcase
		end
		// Read uses next values so a read right after a write sees it
		rdata_next = rdata_reg;
		if (addr_ph && !i_hwrite) begin
			case (raddr)
				fan_pkg::OFF_CTRL: rdata_next = ctrl_next;
				fan_pkg::OFF_THRESH: rdata_next = thr_next;
				fan_pkg::OFF_SPEED: rdata_next = spd_next;
				fan_pkg::OFF_STATUS: begin
					rdata_next = 32'h0;
					rdata_next[fan_pkg::RPM_LSB +: 16] = rpm;
					rdata_next[fan_pkg::DUTY_LSB +: 7] = duty_reg;
					rdata_next[fan_pkg::TGT_LSB +: 7] = tgt_reg;
				end
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// Interval timer built from 100 ms units
	always_comb begin
		tick_next = 1'b0;
		tcnt_next = tcnt_reg + 32'h1;
		icnt_next = icnt_reg;
		if (tcnt_reg == 32'(UPD_STEP_CYCLES - 1)) begin
			tcnt_next = 32'h0;
			if (icnt_reg >= intv - 4'h1) begin
				icnt_next = 4'h0;
				tick_next = 1'b1;
			end else begin
				icnt_next = icnt_reg + 4'h1;
			end
		end
	end

	// Control loop: temperature sampled only on the interval pulse
	always_comb begin
		if (temp_s < lo_c) begin
			tgt = min_pct;
		end else if (temp_s > hi_c) begin
			tgt = max_pct;
		end else if (temp_s < mid_c) begin
			tgt = lspd_pct;
		end else begin
			tgt = uspd_pct;
		end
		tgt_next = tgt_reg;
		duty_next = duty_reg;
		if (!auto_en) begin
			// Manual mode applies the default at once, no slewing
			tgt_next = def_pct;
			duty_next = def_pct;
		end else if (tick_reg) begin
			tgt_next = tgt;
			if (tgt > duty_reg) begin
				duty_next = (tgt - duty_reg > step_pct) ? duty_reg + step_pct : tgt;
			end else begin
				duty_next = (duty_reg - tgt > step_pct) ? duty_reg - step_pct : tgt;
			end
		end
	end

	// Registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= fan_pkg::CTRL_RST;
			thr_reg <= fan_pkg::THRESH_RST;
			spd_reg <= fan_pkg::SPEED_RST;
			rdata_reg <= 32'h0;
			wpend_reg <= 1'b0;
			waddr_reg <= fan_pkg::OFF_NONE;
			tcnt_reg <= 32'h0;
			icnt_reg <= 4'h0;
			tick_reg <= 1'b0;
			duty_reg <= fan_pkg::DUTY_RST;
			tgt_reg <= fan_pkg::DUTY_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			thr_reg <= thr_next;
			spd_reg <= spd_next;
			rdata_reg <= rdata_next;
			wpend_reg <= wpend_next;
			waddr_reg <= waddr_next;
			tcnt_reg <= tcnt_next;
			icnt_reg <= icnt_next;
			tick_reg <= tick_next;
			duty_reg <= duty_next;
			tgt_reg <= tgt_next;
		end
	end

	// Constant bus answer flops: always ready, always OKAY
	logic ready_reg;
	logic resp_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end else begin
			ready_reg <= 1'b1;
			resp_reg <= 1'b0;
		end
	end

	assign o_hrdata = rdata_reg;
	assign o_hreadyout = ready_reg;
	assign o_hresp = resp_reg;

	// PWM output stage
	fan_pwm u_pwm (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_period(period),
		.i_duty(duty_reg),
		.o_pwm(o_pwm)
	);

	// Speed measurement
	fan_tach #(
		.GATE_CYCLES(TACH_GATE_CYCLES)
	) u_tach (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_tach(i_tach),
		.i_ppr_code(ctrl_reg[fan_pkg::PPR_LSB +: 2]),
		.o_rpm(rpm)
	);

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	tick_only_a: assert property ($changed(duty_reg) && $past(auto_en) |-> $past(tick_reg))
		else $error("auto duty changed without interval pulse");
	step_limit_a: assert property ($changed(duty_reg) && $past(auto_en) |-> ((duty_reg > $past(duty_reg)) ? duty_reg - $past(duty_reg) : $past(duty_reg) - duty_reg) <= $past(step_pct))
		else $error("duty moved more than step width");
	default_duty_a: assert property (!auto_en |=> duty_reg == $past(def_pct))
		else $error("manual mode not at default duty");
	below_min_a: assert property (tick_reg && auto_en && temp_s < lo_c |=> tgt_reg == $past(min_pct))
		else $error("below lower limit target not minimum");
	above_max_a: assert property (tick_reg && auto_en && temp_s > hi_c |=> tgt_reg == $past(max_pct))
		else $error("above upper limit target not maximum");
	lower_band_a: assert property (tick_reg && auto_en && temp_s >= lo_c && temp_s <= hi_c && temp_s < mid_c |=> tgt_reg == $past(lspd_pct))
		else $error("lower band target wrong");
endmodule : fan_speed_controller
`default_nettype wire

// ---- bench/fan_model.sv ----
// Behavioural fan: open-collector tach while turning, PWM period and high time measured
`timescale 1ns/1ps
`default_nettype none
module fan_model #(
	parameter int TACH_CYCLES = 20 // Cycles per tach pulse
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Fan drive and tach
	input wire logic i_pwm,
	output logic o_tach,
	// Last measured PWM period and high time in cycles
	output logic [19:0] o_period,
	output logic [19:0] o_high
);
	logic prev_reg; // Drive level seen last cycle
	logic [19:0] pcnt_reg; // Cycles since the last rise
	logic [19:0] hcnt_reg; // High cycles in this period
	logic [15:0] idle_reg; // Cycles since the drive was last high
	int tcnt; // Tach phase within one pulse
	// Rotor coasts a while after drive stops; tach pulls low for five cycles per pulse
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_reg <= 1'b0;
			pcnt_reg <= 20'h0;
			hcnt_reg <= 20'h0;
			idle_reg <= 16'hffff;
			tcnt <= 0;
			o_tach <= 1'b1;
			o_period <= 20'h0;
			o_high <= 20'h0;
		end else begin
			prev_reg <= i_pwm;
			pcnt_reg <= (i_pwm && !prev_reg) ? 20'h1 : pcnt_reg + 20'h1;
			hcnt_reg <= (i_pwm && !prev_reg) ? 20'h1 : hcnt_reg + 20'(i_pwm);
			idle_reg <= i_pwm ? 16'h0 : ((idle_reg == 16'hffff) ? idle_reg : idle_reg + 16'h1);
			tcnt <= (tcnt == TACH_CYCLES - 1) ? 0 : tcnt + 1;
			// Pull-up holds the line high once the rotor has stopped
			o_tach <= !((idle_reg != 16'hffff) && (tcnt < 5));
			if (i_pwm && !prev_reg) begin
				o_period <= pcnt_reg;
			end
			if (!i_pwm && prev_reg) begin
				o_high <= hcnt_reg;
			end
		end
	end
endmodule : fan_model
`default_nettype wire

// ---- bench/tb_fan_speed_controller.sv ----
// Testbench for the fan speed controller: bus tasks, loop, PWM and tach checks
`timescale 1ns/1ps
`default_nettype none
module tb_fan_speed_controller;
	localparam int STEP_CYC = 100; // Shortened 100 ms unit keeps the run short
	localparam int GATE_CYC = 1000; // Shortened one second tach gate
	// Bench drive
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] cpu_t = 8'h14;
	logic [7:0] brd_t = 8'h14;
	// Design outputs
	logic [31:0] hrdata;
	logic hreadyout, hresp, hready, tach, pwm;
	logic [19:0] per, hi;
	// Bench state
	logic [31:0] ctl = fan_pkg::CTRL_RST; // Shadow of the control word
	logic [31:0] rd; // Last read data
	int errors = 0;
	int num_checks = 0;
	int pct [9] = '{0, 10, 25, 40, 50, 60, 75, 90, 100}; // Fixed duty per index
	// Loop table: thresholds, temperature, expected target
	logic [31:0] th [10] = '{32'h805, 32'h805, 32'h805, 32'h805, 32'h805, 32'h805,
		32'h302, 32'h302, 32'h302, 32'h302};
	int tp [10] = '{40, 50, 64, 65, 80, 81, 24, 25, 31, 19};
	int ex [10] = '{10, 60, 60, 80, 80, 100, 60, 80, 100, 10};
	always #50 clock = ~clock;
	assign hready = hreadyout; // Single slave: its ready is the bus ready

	fan_speed_controller #(.UPD_STEP_CYCLES(STEP_CYC), .TACH_GATE_CYCLES(GATE_CYC)) uut (
		.i_clock(clock), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_cpu_temp(cpu_t),
		.i_board_temp(brd_t), .i_tach(tach), .o_pwm(pwm));
	fan_model #(.TACH_CYCLES(20)) fan (.i_clock(clock), .i_rst_b(rst_b), .i_pwm(pwm),
		.o_tach(tach), .o_period(per), .o_high(hi));

	// Verdict and end of run
	task automatic finish_test();
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	// A wait that ran out counts as a mismatch
	task automatic give_up();
		errors++;
		$display("MISMATCH wait expected event seen none");
		finish_test();
	endtask : give_up
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Next edge with ready high, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) give_up();
	endtask : wait_ready
	// One single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, off};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb
	task automatic rd_chk(input string nm, input logic [7:0] off, input int lsb, input int w,
		input logic [31:0] exp);
		ahb(1'b0, off, 32'h0);
		chk(nm, exp, (rd >> lsb) & 32'((64'h1 << w) - 1));
	endtask : rd_chk
	// Update one control field through the shadow and write it
	task automatic set_f(input int lsb, input int w, input int v);
		ctl = (ctl & ~(32'((64'h1 << w) - 1) << lsb)) | (32'(v) << lsb);
		ahb(1'b1, fan_pkg::OFF_CTRL, ctl);
	endtask : set_f
	task automatic wait_pwm(input logic lvl);
		int n;
		n = 0;
		while (pwm !== lvl) begin
			@(posedge clock);
			n++;
			if (n > 20000) give_up();
		end
	endtask : wait_pwm
	// Skip to a whole period under the new setting, then measure it
	task automatic measure(input int p, input int d, input bit whole);
		// One edge first, so a period that started with the write edge is seen as old
		@(posedge clock);
		wait_pwm(1'b0);
		wait_pwm(1'b1);
		wait_pwm(1'b0);
		@(posedge clock);
		chk("pwm high", 32'((p * d + 99) / 100), 32'(hi));
		if (whole) begin
			wait_pwm(1'b1);
			@(posedge clock);
			chk("pwm period", 32'(p), 32'(per));
		end
	endtask : measure

	// Main sequence
	initial begin
		int n;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		// Reset values and an unmapped hole
		rd_chk("ctrl", fan_pkg::OFF_CTRL, 0, 32, fan_pkg::CTRL_RST);
		rd_chk("thresh", fan_pkg::OFF_THRESH, 0, 32, 32'h805);
		rd_chk("speed", fan_pkg::OFF_SPEED, 0, 32, 32'h1410_0c00);
		rd_chk("duty", fan_pkg::OFF_STATUS, fan_pkg::DUTY_LSB, 7, 32'd100);
		ahb(1'b1, 8'h10, 32'hffff_ffff);
		rd_chk("hole", 8'h10, 0, 32, 32'h0);
		// Manual mode: every fixed duty, applied at once
		set_f(fan_pkg::AUTO_BIT, 1, 0);
		for (int i = 0; i < 9; i++) begin
			set_f(fan_pkg::DEF_LSB, 4, i);
			// Duty follows the new default one cycle after the write lands
			@(posedge clock);
			rd_chk("fixed duty", fan_pkg::OFF_STATUS, fan_pkg::DUTY_LSB, 7, 32'(pct[i]));
		end
		// PWM shape in the high range, new values only at period start
		set_f(fan_pkg::DEF_LSB, 4, 4);
		measure(322, 50, 1'b1);
		set_f(fan_pkg::KHZ_LSB, 6, 63);
		measure(158, 50, 1'b1);
		set_f(fan_pkg::DEF_LSB, 4, 2);
		set_f(fan_pkg::KHZ_LSB, 6, 1);
		measure(10000, 25, 1'b1);
		set_f(fan_pkg::KHZ_LSB, 6, 31);
		// Tach: 50 pulses per gate with each pulses-per-rev setting
		for (int c = 0; c < 4; c++) begin
			set_f(fan_pkg::PPR_LSB, 2, c);
			repeat (2 * GATE_CYC + 100) @(posedge clock);
			rd_chk("rpm", fan_pkg::OFF_STATUS, fan_pkg::RPM_LSB, 16, 32'(3000 / (c + 1)));
		end
		// Automatic loop across bands and limits, full step
		ahb(1'b1, fan_pkg::OFF_SPEED, 32'h1410_0c02);
		set_f(fan_pkg::AUTO_BIT, 1, 1);
		for (int i = 0; i < 10; i++) begin
			ahb(1'b1, fan_pkg::OFF_THRESH, th[i]);
			cpu_t <= 8'(tp[i]);
			repeat (250) @(posedge clock);
			rd_chk("target", fan_pkg::OFF_STATUS, fan_pkg::TGT_LSB, 7, 32'(ex[i]));
			rd_chk("duty", fan_pkg::OFF_STATUS, fan_pkg::DUTY_LSB, 7, 32'(ex[i]));
		end
		// Board sensor selected: board in upper band while CPU is cold
		brd_t <= 8'd25;
		set_f(fan_pkg::SEL_BIT, 1, 1);
		repeat (250) @(posedge clock);
		rd_chk("board target", fan_pkg::OFF_STATUS, fan_pkg::TGT_LSB, 7, 32'd80);
		// Slew 80 toward 10 in 8 percent steps once per 1000 cycles
		set_f(fan_pkg::STEP_LSB, 3, 3);
		set_f(fan_pkg::INT_LSB, 4, 10);
		set_f(fan_pkg::SEL_BIT, 1, 0);
		n = 0;
		do begin
			ahb(1'b0, fan_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[22:16] === 7'h50 && n < 600);
		if (rd[22:16] === 7'h50) give_up();
		chk("first step", 32'd72, 32'(rd[22:16]));
		repeat (10 * STEP_CYC - 10) @(posedge clock);
		rd_chk("held step", fan_pkg::OFF_STATUS, fan_pkg::DUTY_LSB, 7, 32'd72);
		repeat (20) @(posedge clock);
		rd_chk("second step", fan_pkg::OFF_STATUS, fan_pkg::DUTY_LSB, 7, 32'd64);
		// Low range at 88.2 Hz with 10 percent fixed duty
		set_f(fan_pkg::AUTO_BIT, 1, 0);
		set_f(fan_pkg::DEF_LSB, 4, 1);
		set_f(fan_pkg::LF_LSB, 3, 7);
		set_f(fan_pkg::HIGH_BIT, 1, 0);
		measure(int'(fan_pkg::LF_PERIOD[7]), 10, 1'b0);
		finish_test();
	end
endmodule : tb_fan_speed_controller
`default_nettype wire
